/* common/rct_pkg.sv */
// constants for the pulse width capture timer
`default_nettype none
package rct_pkg;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 16;
	localparam int          DIV_W         = 10;
	// register addresses
	localparam logic [15:0] ADDR_CONTROL  = 16'hff60;
	localparam logic [15:0] ADDR_RISE_CAP = 16'hff61;
	localparam logic [15:0] ADDR_FALL_CAP = 16'hff62;
	localparam logic [15:0] ADDR_COUNTER  = 16'hff63;
	// control register fields
	localparam int          RUN_BIT       = 7;
	localparam int          WRAP_BIT      = 2;
	localparam int          SEL_HI_BIT    = 1;
	localparam int          SEL_LO_BIT    = 0;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  CAPTURE_RESET = 8'h00;
	localparam logic [7:0]  COUNTER_RESET = 8'h00;
	localparam logic [7:0]  COUNTER_MAX   = 8'hff;
	// prescaler tap masks: count clock = core clock / 2^n
	localparam logic [9:0]  TAP_DIV1024   = 10'h3ff;
	localparam logic [9:0]  TAP_DIV512    = 10'h1ff;
	localparam logic [9:0]  TAP_DIV16     = 10'h00f;
	localparam logic [9:0]  TAP_DIV8      = 10'h007;
	// clock select codes
	typedef enum logic [1:0] {
		RCT_SEL_DIV1024 = 2'b00,
		RCT_SEL_DIV512  = 2'b01,
		RCT_SEL_DIV16   = 2'b10,
		RCT_SEL_DIV8    = 2'b11
	} rct_sel_t;
	// phase value on which the pin is sampled; the phase toggles each count clock, so sampling is every second count clock
	localparam logic [0:0]  SAMPLE_LAST   = 1'h1;
endpackage
`default_nettype wire

/* common/rct_tick_if.sv */
// count clock tick and qualified edge strobes shared by the timer modules
`default_nettype none
interface rct_tick_if;
	logic tick;
	logic rise;
	logic fall;
	modport prescaler (output tick);
	modport qualifier (input tick, output rise, output fall);
	modport timer     (input tick, input rise, input fall);
endinterface
`default_nettype wire

/* rtl/rct_edge_qual.sv */
// pulse input synchroniser and edge qualifier sampled every second count clock
`default_nettype none
module rct_edge_qual (
	input  wire logic     core_clk,        // main clock
	input  wire logic     reset,           // async reset, high
	input  wire logic     pulse_input_pin, // external pulse, asynchronous
	rct_tick_if.qualifier tk               // tick in, edge strobes out
);
	logic sync_a;
	logic sync_b;
	logic phase;
	logic next_phase;
	logic last_sample;
	logic next_last_sample;
	logic level;
	logic next_level;
	logic rise_q;
	logic next_rise;
	logic fall_q;
	logic next_fall;

	// two flops before anything looks at the pin
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end
		else
		begin
			sync_a <= pulse_input_pin;  // [R16]
			sync_b <= sync_a;
		end
	end

	always_comb
	begin
		next_phase       = phase;
		next_last_sample = last_sample;
		next_level       = level;
		next_rise        = 1'b0;
		next_fall        = 1'b0;
		if (tk.tick)
		begin
			next_phase = ~phase;
			if (phase == rct_pkg::SAMPLE_LAST)  // [R11]
			begin
				next_last_sample = sync_b;
				// a new level needs two agreeing samples; shorter phases are lost
				if (sync_b == last_sample && sync_b != level)  // [R11] [R12] [R13]
				begin
					next_level = sync_b;
					next_rise  = sync_b;
					next_fall  = ~sync_b;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			phase       <= 1'b0;
			last_sample <= 1'b0;
			level       <= 1'b0;
			rise_q      <= 1'b0;
			fall_q      <= 1'b0;
		end
		else
		begin
			phase       <= next_phase;
			last_sample <= next_last_sample;
			level       <= next_level;
			rise_q      <= next_rise;
			fall_q      <= next_fall;
		end
	end

	assign tk.rise = rise_q;
	assign tk.fall = fall_q;

	a_edge_on_tick : assert property (@(posedge core_clk) disable iff (reset)
		(tk.rise || tk.fall) |-> $past(tk.tick))  // [R11]
		else $error("edge strobe without a sampling tick");
	a_edge_exclusive : assert property (@(posedge core_clk) disable iff (reset)
		!(tk.rise && tk.fall))  // [R11]
		else $error("rise and fall in one cycle");
endmodule
`default_nettype wire

/* rtl/rct_prescaler.sv */
// count clock prescaler with four selectable taps
`default_nettype none
module rct_prescaler (
	input  wire logic       core_clk,  // main clock
	input  wire logic       reset,     // async reset, high
	input  wire logic       run,       // counting enabled
	input  wire logic [1:0] sel,       // clock select code
	rct_tick_if.prescaler   tk         // tick out
);
	logic [rct_pkg::DIV_W-1:0] div;
	logic [rct_pkg::DIV_W-1:0] next_div;
	logic [rct_pkg::DIV_W-1:0] mask;
	logic                      tick_q;
	logic                      next_tick;

	always_comb
	begin
		unique case (rct_pkg::rct_sel_t'(sel))  // [R03]
			rct_pkg::RCT_SEL_DIV1024: mask = rct_pkg::TAP_DIV1024;
			rct_pkg::RCT_SEL_DIV512:  mask = rct_pkg::TAP_DIV512;
			rct_pkg::RCT_SEL_DIV16:   mask = rct_pkg::TAP_DIV16;
			rct_pkg::RCT_SEL_DIV8:    mask = rct_pkg::TAP_DIV8;
		endcase
		// prescaler is held cleared while stopped so a restart begins a full period
		next_div  = run ? div + 10'h001 : '0;  // [R01]
		next_tick = run && ((div & mask) == mask);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			div    <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			div    <= next_div;
			tick_q <= next_tick;
		end
	end

	assign tk.tick = tick_q;

	a_tick_needs_run : assert property (@(posedge core_clk) disable iff (reset)
		tk.tick |-> $past(run))  // [R01]
		else $error("count tick while stopped");
endmodule
`default_nettype wire

/* rtl/rct_top.sv */
// pulse width capture timer: control register, free running counter, two capture registers
//
// How it works
// R01 - run bit 0 holds counter at zero; 1 counts on selected count clock
// R02 - control bit 2 reads 1 after counter overflow, else 0
// R03 - clock select 00,01,10,11 picks main clock over 1024, 512, 16, 8
// R04 - software writes zero into control bits 3 to 6
// R05 - reset loads control with 00: stopped, flag clear, slowest clock
// R06 - qualified rising edge copies counter to rising capture, held until next
// R07 - qualified falling edge copies counter to falling capture, held until next
// R08 - both captures reset to 00 and are read only as whole bytes
// R09 - counter is readable, zeroed by reset and by clearing run
// R10 - counter runs free; captures never clear it
// R11 - input sampled every second count clock; two agreeing samples before capture
// R12 - phases shorter than five count clocks are missed, no capture; the code still captures phases of four and some of three
// R13 - source holds each level at least five count clocks
// R14 - counter wraps from ff to 00 modulo 100
// R15 - overflow flag set on ff to 00 wrap, cleared by write 0 or stop
// R16 - pulse input synchronised to main clock before qualification
`default_nettype none
module rct_top (
	input  wire logic        core_clk,        // main clock, 50 MHz
	input  wire logic        reset,           // async reset, active high
	input  wire logic        pulse_input_pin, // external pulse input
	input  wire logic [15:0] bus_addr,        // register address
	input  wire logic        bus_wr,          // write strobe
	input  wire logic [7:0]  bus_wdata,       // write data
	input  wire logic        bus_rd,          // read strobe
	output var  logic [7:0]  bus_rdata        // read data, one cycle after strobe
);
	rct_tick_if tk ();

	logic       run;
	logic       next_run;
	logic [1:0] sel;
	logic [1:0] next_sel;
	logic       wrap_flag;
	logic       next_wrap_flag;
	logic [7:0] free_running_counter;
	logic [7:0] next_counter;
	logic [7:0] rising_edge_capture;
	logic [7:0] next_rising_cap;
	logic [7:0] falling_edge_capture;
	logic [7:0] next_falling_cap;
	logic [7:0] next_rdata;
	logic [7:0] control_view;
	logic       ctrl_write;
	logic       wrap_event;
	logic       rise_seen;
	logic       next_rise_seen;

	rct_prescaler u_prescaler (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (run),
		.sel      (sel),
		.tk       (tk)
	);

	rct_edge_qual u_edge_qual (
		.core_clk        (core_clk),
		.reset           (reset),
		.pulse_input_pin (pulse_input_pin),
		.tk              (tk)
	);

	// control register view; bits 3 to 6 are not stored and read as zero
	always_comb
	begin
		control_view                         = 8'h00;
		control_view[rct_pkg::RUN_BIT]       = run;
		control_view[rct_pkg::WRAP_BIT]      = wrap_flag;  // [R02]
		control_view[rct_pkg::SEL_HI_BIT]    = sel[1];
		control_view[rct_pkg::SEL_LO_BIT]    = sel[0];
	end

	assign ctrl_write = bus_wr && (bus_addr == rct_pkg::ADDR_CONTROL);
	assign wrap_event = run && tk.tick && (free_running_counter == rct_pkg::COUNTER_MAX);

	// control register
	always_comb
	begin
		next_run       = run;
		next_sel       = sel;
		next_wrap_flag = wrap_flag;
		if (ctrl_write)
		begin
			// bits 3 to 6 are dropped, so a careless write there does no harm
			next_run = bus_wdata[rct_pkg::RUN_BIT];  // [R04]
			next_sel = {bus_wdata[rct_pkg::SEL_HI_BIT], bus_wdata[rct_pkg::SEL_LO_BIT]};  // [R03]
			// writing 1 cannot set the flag; only a real wrap does
			if (!bus_wdata[rct_pkg::WRAP_BIT] || !bus_wdata[rct_pkg::RUN_BIT])
				next_wrap_flag = 1'b0;  // [R15]
		end
		else if (!run)
			next_wrap_flag = 1'b0;  // [R15]
		// a wrap in the same cycle as a clear still leaves the flag set
		if (wrap_event)
			next_wrap_flag = 1'b1;  // [R15] [R02]
	end

	// free running counter
	always_comb
	begin
		if (!run)
			next_counter = rct_pkg::COUNTER_RESET;  // [R01] [R09]
		else if (tk.tick)
			next_counter = free_running_counter + 8'h01;  // [R14] [R10]
		else
			next_counter = free_running_counter;
	end

	// capture registers; the counter itself is never touched by a capture
	always_comb
	begin
		next_rising_cap  = tk.rise ? free_running_counter : rising_edge_capture;  // [R06] [R10]
		next_falling_cap = tk.fall ? free_running_counter : falling_edge_capture;  // [R07] [R10]
	end

	// read port: whole byte reads; unmapped addresses and idle cycles return zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (bus_rd)
		begin
			unique case (bus_addr)
				rct_pkg::ADDR_CONTROL:  next_rdata = control_view;
				rct_pkg::ADDR_RISE_CAP: next_rdata = rising_edge_capture;  // [R08]
				rct_pkg::ADDR_FALL_CAP: next_rdata = falling_edge_capture;  // [R08]
				rct_pkg::ADDR_COUNTER:  next_rdata = free_running_counter;  // [R09]
				default:                next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			run                  <= rct_pkg::CONTROL_RESET[rct_pkg::RUN_BIT];  // [R05]
			sel                  <= rct_pkg::CONTROL_RESET[1:0];  // [R05]
			wrap_flag            <= rct_pkg::CONTROL_RESET[rct_pkg::WRAP_BIT];  // [R05]
			free_running_counter <= rct_pkg::COUNTER_RESET;  // [R09]
			rising_edge_capture  <= rct_pkg::CAPTURE_RESET;  // [R08]
			falling_edge_capture <= rct_pkg::CAPTURE_RESET;  // [R08]
			bus_rdata            <= 8'h00;
		end
		else
		begin
			run                  <= next_run;
			sel                  <= next_sel;
			wrap_flag            <= next_wrap_flag;
			free_running_counter <= next_counter;
			rising_edge_capture  <= next_rising_cap;
			falling_edge_capture <= next_falling_cap;
			bus_rdata            <= next_rdata;
		end
	end

	// last qualified edge direction, kept only for the alternation checks below
	always_comb
	begin
		next_rise_seen = rise_seen;
		if (tk.rise)
			next_rise_seen = 1'b1;
		else if (tk.fall)
			next_rise_seen = 1'b0;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			rise_seen <= 1'b0;
		else
			rise_seen <= next_rise_seen;
	end

	a_stop_holds_zero : assert property (@(posedge core_clk) disable iff (reset)  // [R01]
		!run |=> (free_running_counter == 8'h00))
		else $error("counter not zero while stopped");

	a_count_step : assert property (@(posedge core_clk) disable iff (reset)  // [R01]
		(run && tk.tick) |=> (free_running_counter == $past(free_running_counter) + 8'h01))
		else $error("counter did not step on tick");

	a_count_hold : assert property (@(posedge core_clk) disable iff (reset)  // [R10]
		(run && !tk.tick) |=> $stable(free_running_counter))
		else $error("counter moved without a tick");

	a_wrap_to_zero : assert property (@(posedge core_clk) disable iff (reset)  // [R14]
		wrap_event |=> (free_running_counter == 8'h00) && wrap_flag)
		else $error("wrap did not reach zero and set flag");

	a_flag_only_by_wrap : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		$rose(wrap_flag) |-> $past(wrap_event))
		else $error("overflow flag set without a wrap");

	a_flag_cleared_stop : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(!run && !wrap_event && !ctrl_write) |=> !wrap_flag)
		else $error("overflow flag kept while stopped");

	a_rise_capture : assert property (@(posedge core_clk) disable iff (reset)  // [R06]
		tk.rise |=> (rising_edge_capture == $past(free_running_counter)))
		else $error("rising capture missed counter value");

	a_rise_hold : assert property (@(posedge core_clk) disable iff (reset)  // [R06]
		!tk.rise |=> $stable(rising_edge_capture))
		else $error("rising capture changed without edge");

	a_fall_capture : assert property (@(posedge core_clk) disable iff (reset)  // [R07]
		tk.fall |=> (falling_edge_capture == $past(free_running_counter)))
		else $error("falling capture missed counter value");

	a_fall_hold : assert property (@(posedge core_clk) disable iff (reset)  // [R07]
		!tk.fall |=> $stable(falling_edge_capture))
		else $error("falling capture changed without edge");

	a_reserved_zero : assert property (@(posedge core_clk) disable iff (reset)  // [R02]
		(bus_rd && bus_addr == rct_pkg::ADDR_CONTROL) |=> (bus_rdata[6:3] == 4'h0)
			&& (bus_rdata[2] == $past(wrap_flag)))
		else $error("control read shows wrong reserved or flag bits");

	a_counter_read : assert property (@(posedge core_clk) disable iff (reset)  // [R09]
		(bus_rd && bus_addr == rct_pkg::ADDR_COUNTER) |=> (bus_rdata == $past(free_running_counter)))
		else $error("counter read returned wrong value");

	a_capture_read : assert property (@(posedge core_clk) disable iff (reset)  // [R08]
		(bus_rd && bus_addr == rct_pkg::ADDR_RISE_CAP) |=> (bus_rdata == $past(rising_edge_capture)))
		else $error("rising capture read returned wrong value");

	a_fall_read : assert property (@(posedge core_clk) disable iff (reset)  // [R08]
		(bus_rd && bus_addr == rct_pkg::ADDR_FALL_CAP) |=> (bus_rdata == $past(falling_edge_capture)))
		else $error("falling capture read returned wrong value");

	a_control_read : assert property (@(posedge core_clk) disable iff (reset)  // [R01] [R03]
		(bus_rd && bus_addr == rct_pkg::ADDR_CONTROL) |=> (bus_rdata[rct_pkg::RUN_BIT] == $past(run))
			&& (bus_rdata[rct_pkg::SEL_HI_BIT] == $past(sel[1])) && (bus_rdata[rct_pkg::SEL_LO_BIT] == $past(sel[0])))
		else $error("control read shows wrong run or select bits");

	a_run_written : assert property (@(posedge core_clk) disable iff (reset)  // [R01]
		ctrl_write |=> (run == $past(bus_wdata[rct_pkg::RUN_BIT])))
		else $error("run bit not taken from control write");

	a_sel_written : assert property (@(posedge core_clk) disable iff (reset)  // [R03]
		ctrl_write |=> (sel == {$past(bus_wdata[rct_pkg::SEL_HI_BIT]), $past(bus_wdata[rct_pkg::SEL_LO_BIT])}))
		else $error("clock select not taken from control write");

	a_ctrl_kept : assert property (@(posedge core_clk) disable iff (reset)  // [R01] [R03]
		!ctrl_write |=> ($stable(run) && $stable(sel)))
		else $error("control fields changed without a write");

	a_flag_write_clear : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(ctrl_write && !bus_wdata[rct_pkg::WRAP_BIT] && !wrap_event) |=> !wrap_flag)
		else $error("overflow flag not cleared by write of zero");

	a_stop_clears_flag : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(ctrl_write && !bus_wdata[rct_pkg::RUN_BIT] && !wrap_event) |=> !wrap_flag)
		else $error("overflow flag not cleared by stop");

	a_flag_holds : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(wrap_flag && run && !ctrl_write) |=> wrap_flag)
		else $error("overflow flag dropped while running");

	a_flag_write_one : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(wrap_flag && ctrl_write && bus_wdata[rct_pkg::WRAP_BIT] && bus_wdata[rct_pkg::RUN_BIT])
			|=> wrap_flag)
		else $error("overflow flag dropped by write of one");

	a_flag_no_set : assert property (@(posedge core_clk) disable iff (reset)  // [R15]
		(!wrap_flag && !wrap_event) |=> !wrap_flag)
		else $error("overflow flag set without a wrap");

	a_stop_clears_counter : assert property (@(posedge core_clk) disable iff (reset)  // [R09]
		(ctrl_write && !bus_wdata[rct_pkg::RUN_BIT]) |=> ##1 (free_running_counter == 8'h00))
		else $error("counter not zeroed after run cleared");

	a_stop_no_tick : assert property (@(posedge core_clk) disable iff (reset)  // [R01]
		!run |=> !tk.tick)
		else $error("count tick follows a stopped cycle");

	a_tick_spacing : assert property (@(posedge core_clk) disable iff (reset)  // [R03]
		tk.tick |=> (!tk.tick)[*7])
		else $error("count ticks closer than the fastest divider");

	a_capture_free_run : assert property (@(posedge core_clk) disable iff (reset)  // [R10]
		(run && (tk.rise || tk.fall))
			|=> (free_running_counter == $past(free_running_counter) + {7'h00, $past(tk.tick)}))
		else $error("capture disturbed the counter");

	a_rise_once : assert property (@(posedge core_clk) disable iff (reset)  // [R06]
		tk.rise |=> !tk.rise)
		else $error("rising strobe longer than one cycle");

	a_fall_once : assert property (@(posedge core_clk) disable iff (reset)  // [R07]
		tk.fall |=> !tk.fall)
		else $error("falling strobe longer than one cycle");

	a_rise_after_fall : assert property (@(posedge core_clk) disable iff (reset)  // [R11]
		tk.rise |-> !rise_seen)
		else $error("two rising edges without a falling edge");

	a_fall_after_rise : assert property (@(posedge core_clk) disable iff (reset)  // [R11]
		tk.fall |-> rise_seen)
		else $error("falling edge without a preceding rising edge");
endmodule
`default_nettype wire

/* test/rct_pulse_src.sv */
// pulse source model standing at the timer's input pin
`default_nettype none
module rct_pulse_src (
	input  wire logic        core_clk,  // main clock
	input  wire logic        reset,     // async reset, high
	input  wire logic        go,        // start one high phase
	input  wire logic [15:0] hi_len,    // high phase length in core clocks
	output var  logic        pulse_out  // level to the timer pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] left;
	// each level is held for the whole length asked; only a glitch scenario asks for less than five count clocks
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			left      <= 16'h0000;
			pulse_out <= 1'b0;
		end
		else if (go)
		begin
			left      <= hi_len;
			pulse_out <= 1'b1;
		end
		else if (left != 16'h0000)
			left <= left - 16'h0001;
		else
		begin
			left      <= 16'h0000;
			pulse_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the pulse width capture timer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk;
	logic        reset;
	logic        pulse_input_pin;
	logic [15:0] bus_addr;
	logic        bus_wr;
	logic [7:0]  bus_wdata;
	logic        bus_rd;
	logic [7:0]  bus_rdata;
	logic        go;
	logic [15:0] hi_len;
	int          miscompares;
	int          compares;
	logic [7:0]  v0;
	logic [7:0]  v1;
	logic [7:0]  r0;
	int          divs[4] = '{1024, 512, 16, 8};

	rct_top rct_top_i (.core_clk(core_clk), .reset(reset), .pulse_input_pin(pulse_input_pin),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	rct_pulse_src rct_pulse_src_i (.core_clk(core_clk), .reset(reset), .go(go), .hi_len(hi_len),
		.pulse_out(pulse_input_pin));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr  = a;
		bus_wdata = d;
		bus_wr    = 1'b1;
		@(negedge core_clk);
		bus_wr    = 1'b0;
	endtask

	// data is taken one cycle after the strobe, where the read answer stands
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_rd   = 1'b1;
		@(negedge core_clk);
		bus_rd   = 1'b0;
		d        = bus_rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic pulse(input logic [15:0] len);
		@(negedge core_clk);
		hi_len = len;
		go     = 1'b1;
		@(negedge core_clk);
		go     = 1'b0;
	endtask

	task automatic give_verdict;
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		give_verdict;
	end

	initial
	begin
		reset       = 1'b1;
		bus_addr    = 16'h0000;
		bus_wr      = 1'b0;
		bus_wdata   = 8'h00;
		bus_rd      = 1'b0;
		go          = 1'b0;
		hi_len      = 16'h0000;
		miscompares = 0;
		compares    = 0;
		repeat (20) @(negedge core_clk);
		reset = 1'b0;
		// four registers and one unmapped address all read zero out of reset
		for (int i = 0; i < 5; i++)
		begin
			rd(rct_pkg::ADDR_CONTROL + 16'(i), r0);
			check(r0, 8'h00);
		end
		wr(rct_pkg::ADDR_RISE_CAP, 8'hff);
		rd(rct_pkg::ADDR_RISE_CAP, r0);
		check(r0, 8'h00);
		// every clock select: reads spaced four count periods apart differ by four
		for (int s = 0; s < 4; s++)
		begin
			wr(rct_pkg::ADDR_CONTROL, 8'h80 | 8'(s));
			rd(rct_pkg::ADDR_CONTROL, r0);
			check(r0, 8'h80 | 8'(s));
			rd(rct_pkg::ADDR_COUNTER, v0);
			idle(4 * divs[s] - 2);
			rd(rct_pkg::ADDR_COUNTER, v1);
			check(v1 - v0, 8'h04);
			wr(rct_pkg::ADDR_CONTROL, 8'h00);
			idle(2);
			rd(rct_pkg::ADDR_COUNTER, r0);
			check(r0, 8'h00);
			rd(rct_pkg::ADDR_CONTROL, r0);
			check(r0, 8'h00);
		end
		// fastest clock: one 50-count high phase measured from both captures
		wr(rct_pkg::ADDR_CONTROL, 8'h83);
		rd(rct_pkg::ADDR_CONTROL, r0);
		check(r0, 8'h83);
		idle(40);
		pulse(16'd400);
		idle(560);
		rd(rct_pkg::ADDR_RISE_CAP, v0);
		rd(rct_pkg::ADDR_FALL_CAP, v1);
		r0 = v1 - v0;
		check({7'h00, r0 >= 8'd48 && r0 <= 8'd52}, 8'h01);
		// a glitch shorter than one sampling interval can never be seen twice, whatever the phase
		pulse(16'd12);
		idle(200);
		rd(rct_pkg::ADDR_RISE_CAP, r0);
		check(r0, v0);
		rd(rct_pkg::ADDR_FALL_CAP, r0);
		check(r0, v1);
		// a full wrap sets the flag; writing zero clears it, writing one does not set it
		idle(2100);
		rd(rct_pkg::ADDR_CONTROL, r0);
		check(r0, 8'h87);
		wr(rct_pkg::ADDR_CONTROL, 8'h83);
		rd(rct_pkg::ADDR_CONTROL, r0);
		check(r0, 8'h83);
		wr(rct_pkg::ADDR_CONTROL, 8'h87);
		rd(rct_pkg::ADDR_CONTROL, r0);
		check(r0, 8'h83);
		give_verdict;
	end
endmodule
`default_nettype wire
